// ### cil_pkg.sv
/*
  shared constants for the configuration image loader: link address map,
  firmware-data cells, release code, timing counts and host register map.
  assumes a single 20 MHz clock shared by both ends.
*/
package cil_pkg;
  localparam longint CLK_HZ   = 20_000_000;               // system clock rate
  localparam longint T_HOUR_S = 3600;                     // refresh period, seconds
  localparam longint T_WDT_S  = 13;                       // watchdog timeout, seconds
  localparam logic [39:0] HOUR_CYC = 40'(T_HOUR_S * CLK_HZ); // refresh period, cycles
  localparam logic [27:0] WDT_CYC  = 28'(T_WDT_S * CLK_HZ);  // watchdog period, cycles
  // link word addresses
  localparam logic [8:0] A_FWD_BASE   = 9'h100;           // firmware-data cell 0
  localparam logic [8:0] A_CTRL       = 9'h010;           // loader control word
  localparam logic [8:0] A_STAT       = 9'h011;           // loader status word
  localparam logic [8:0] A_MIN_AMP    = 9'h155;           // min_amplitude_limit
  localparam logic [8:0] A_FHL_PROV   = 9'h15d;           // provisional first-hit level
  localparam logic [8:0] A_CSUM_CODE  = 9'h164;           // reference code checksum
  localparam logic [8:0] A_CSUM_DATA  = 9'h165;           // reference data checksum
  localparam logic [8:0] A_FW_OPT     = 9'h16a;           // firmware_option_word
  localparam logic [8:0] A_FHL        = 9'h16b;           // first-hit level cell
  localparam logic [8:0] A_REFRESH    = 9'h16c;           // refresh_enable_word, image start
  localparam logic [8:0] A_PRC        = 9'h174;           // processing_control_word
  localparam logic [8:0] A_RELEASE    = 9'h17b;           // boot_release_word
  localparam logic [8:0] A_CSUM_FIRST = 9'h17c;           // image_checksum_first
  localparam logic [8:0] A_CSUM_LAST  = 9'h17f;           // image_checksum_last
  localparam int CFG_WORDS = 15;                          // image words copied to live
  localparam logic [31:0] REL_CODE = 32'habcd7654;        // release code value
  localparam int TOF_MSB = 31;                            // top_byte of processing word
  localparam int TOF_LSB = 24;
  localparam int PP_EN_IDX = 1;                           // live word holding pp enable
  localparam int PP_EN_BIT = 0;
  localparam int FORCE_IDX = 0;                           // live word forced after load
  localparam int CTL_WDT_EN = 0;                          // control: watchdog enable
  localparam int CTL_CSUM   = 1;                          // control: start checksum
  // host avalon register map (word index)
  localparam logic [1:0] HR_ADDR  = 2'h0;
  localparam logic [1:0] HR_WDATA = 2'h1;
  localparam logic [1:0] HR_CMD   = 2'h2;
  localparam logic [1:0] HR_RDATA = 2'h3;
  localparam int CMD_GO  = 0;                             // start one link transfer
  localparam int CMD_WR  = 1;                             // transfer is a write
  localparam int CMD_ARM = 2;                             // write release code instead
endpackage : cil_pkg

// ### cil_link_if.sv
/*
  link between the host end and the loader end: single request, single
  registered acknowledge. assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface cil_link_if;
  logic        req;    // request held until ack
  logic        we;     // 1 write, 0 read
  logic [8:0]  addr;   // word address
  logic [31:0] wdata;  // write data
  logic [31:0] rdata;  // read data, valid with ack
  logic        ack;    // one-cycle acknowledge
  modport dev (input req, we, addr, wdata, output rdata, ack);
  modport hst (output req, we, addr, wdata, input rdata, ack);
endinterface : cil_link_if

// ### cil_loader.sv
/*
  device end: firmware-data memory, live configuration registers, boot and
  hourly loader, watchdog, data checksum. assumes a host on cil_link_if on
  the same clock.
*/
// Summary of operation
// - image lives in cells 108 to 122
// - release code arms boot loading
// - boot copies cells 108-122 when armed
// - non-zero cell 108 gives hourly refresh
// - repetition rate in processing word top byte
// - host writes top byte unless rate one
// - stored pp enable gates post-processing
// - host disables pp and watchdog temporarily
// - first-hit levels from cells 93, 107
// - option word in cell 106 steers firmware
// - minimum amplitude stored in cell 85
// - checksums occupy cells 124 to 127
// - stored data checked against checksum cell 124
// - loader may force settings after load
// - device computes checksum for external compare
// - watchdog timeout resets and reloads image
`timescale 1ns/1ps
module cil_loader
  import cil_pkg::*;
#(
  parameter logic [39:0] P_HOUR_CYC = HOUR_CYC,        // hourly refresh period
  parameter logic [27:0] P_WDT_CYC  = WDT_CYC,         // watchdog timeout
  parameter logic [31:0] P_FORCE    = 32'h0000_0000    // bits forced on after load
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_arst_n,
  input  wire logic                          i_ce,
  input  wire logic                          i_wdt_service,
  cil_link_if.dev                            lk,
  output logic [CFG_WORDS-1:0][31:0]         o_live_cfg,
  output logic                               o_pp_run,
  output logic [7:0]                         o_tof_rate,
  output logic [31:0]                        o_min_amp,
  output logic [31:0]                        o_fw_opt,
  output logic [31:0]                        o_fhl_prov,
  output logic [31:0]                        o_fhl,
  output logic                               o_loading,
  output logic [31:0]                        o_data_csum,
  output logic                               o_csum_ok,
  output logic                               o_wdt_reset
);
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_LOAD, ST_CSUM} cil_dst_t;

  typedef struct packed {
    cil_dst_t                  st;       // loader state
    logic [3:0]                idx;      // image word being copied
    logic [6:0]                cidx;     // cell being summed
    logic [CFG_WORDS-1:0][31:0] live;    // live configuration registers
    logic                      ack;      // link acknowledge
    logic [31:0]               rdata;    // link read data
    logic [39:0]               hour;     // refresh timer
    logic [27:0]               wdt;      // watchdog timer
    logic                      wdt_en;   // watchdog enabled
    logic                      wdt_rst;  // watchdog reset pulse
    logic [31:0]               csum;     // checksum accumulator / result
    logic                      csum_ok;  // result matched stored word
    logic [7:0]                tof;      // repetition rate copy
    logic [31:0]               min_amp;  // amplitude limit copy
    logic [31:0]               fw_opt;   // option word copy
    logic [31:0]               fhl_prov; // provisional first-hit level copy
    logic [31:0]               fhl;      // first-hit level copy
    logic                      loading;  // boot or load in progress
  } cil_dev_t;

  localparam logic [6:0] C_FIRST   = 7'(A_REFRESH - A_FWD_BASE);
  localparam logic [6:0] C_RELEASE = 7'(A_RELEASE - A_FWD_BASE);
  localparam logic [6:0] C_CSUM    = 7'(A_CSUM_FIRST - A_FWD_BASE);

  logic [31:0] mem [0:127];    // nonvolatile firmware-data cells, no reset
  cil_dev_t    s_r;            // registered state
  cil_dev_t    s_nxt;          // next state
  logic        take;           // link request accepted this cycle
  logic [31:0] sum;            // running sum including current cell
  logic [31:0] img;            // image word being loaded

  // address falls in the firmware-data window
  function automatic logic is_fwd(input logic [8:0] a);
    return a >= A_FWD_BASE && a <= A_CSUM_LAST;
  endfunction : is_fwd

  // cell number of a firmware-data address
  function automatic logic [6:0] cell_of(input logic [8:0] a);
    return 7'(a - A_FWD_BASE);
  endfunction : cell_of

  assign take = lk.req && !s_r.ack;

  // next-state logic
  always_comb begin
    s_nxt         = s_r;
    sum           = s_r.csum + mem[s_r.cidx];
    img           = mem[7'(C_FIRST + 7'(s_r.idx))];
    s_nxt.ack     = 1'b0;
    s_nxt.wdt_rst = 1'b0;
    // link access: read answer or live/control write
    if (take) begin
      s_nxt.ack = 1'b1;
      if (is_fwd(lk.addr)) begin
        s_nxt.rdata = mem[cell_of(lk.addr)];
      end else if (lk.addr < 9'(CFG_WORDS)) begin
        s_nxt.rdata = s_r.live[lk.addr[3:0]];
        if (lk.we) begin
          s_nxt.live[lk.addr[3:0]] = lk.wdata;
        end
      end else if (lk.addr == A_CTRL) begin
        s_nxt.rdata = {31'h0, s_r.wdt_en};
        if (lk.we) begin
          s_nxt.wdt_en = lk.wdata[CTL_WDT_EN];
          if (lk.wdata[CTL_CSUM] && s_r.st == ST_IDLE) begin
            s_nxt.st   = ST_CSUM;
            s_nxt.cidx = 7'h00;
            s_nxt.csum = 32'h0000_0000;
          end
        end
      end else if (lk.addr == A_STAT) begin
        s_nxt.rdata = {29'h0, s_r.csum_ok, s_r.st != ST_IDLE, s_r.wdt_en};
      end else begin
        s_nxt.rdata = 32'h0000_0000; // unmapped reads zero
      end
    end
    // watchdog: service clears, timeout restarts the boot load
    if (!s_r.wdt_en || i_wdt_service) begin
      s_nxt.wdt = 28'h0;
    end else if (s_r.wdt == P_WDT_CYC - 28'h1) begin
      s_nxt.wdt     = 28'h0;
      s_nxt.wdt_rst = 1'b1;
      s_nxt.st      = ST_BOOT;
    end else begin
      s_nxt.wdt = s_r.wdt + 28'h1;
    end
    // hourly timer, holds at terminal count until the loader is idle
    if (s_r.hour < P_HOUR_CYC - 40'h1) begin
      s_nxt.hour = s_r.hour + 40'h1;
    end else if (s_r.st == ST_IDLE && !s_nxt.wdt_rst) begin
      s_nxt.hour = 40'h0;
      if (mem[C_FIRST] != 32'h0000_0000) begin
        s_nxt.st  = ST_LOAD;
        s_nxt.idx = 4'h0;
      end
    end
    // loader sequence
    case (s_r.st)
      ST_BOOT: begin
        if (!s_nxt.wdt_rst) begin
          s_nxt.idx = 4'h0;
          // an unwritten release cell must leave the loader idle, not unknown
          if (mem[C_RELEASE] == REL_CODE) begin
            s_nxt.st = ST_LOAD;
          end else begin
            s_nxt.st = ST_IDLE;
          end
        end
      end
      ST_LOAD: begin
        if (!s_nxt.wdt_rst) begin
          s_nxt.live[s_r.idx] = img;
          if (s_r.idx == 4'(CFG_WORDS - 1)) begin
            s_nxt.live[FORCE_IDX] = s_nxt.live[FORCE_IDX] | P_FORCE;
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.idx = s_r.idx + 4'h1;
          end
        end
      end
      ST_CSUM: begin
        if (!s_nxt.wdt_rst) begin
          s_nxt.csum = sum;
          if (s_r.cidx == C_RELEASE) begin
            s_nxt.csum_ok = (sum == mem[C_CSUM]);
            s_nxt.st      = ST_IDLE;
          end else begin
            s_nxt.cidx = s_r.cidx + 7'h1;
          end
        end
      end
      default: begin
      end
    endcase
    // firmware parameter copies taken straight from the cells
    s_nxt.tof      = mem[cell_of(A_PRC)][TOF_MSB:TOF_LSB];
    s_nxt.min_amp  = mem[cell_of(A_MIN_AMP)];
    s_nxt.fw_opt   = mem[cell_of(A_FW_OPT)];
    s_nxt.fhl_prov = mem[cell_of(A_FHL_PROV)];
    s_nxt.fhl      = mem[cell_of(A_FHL)];
    // busy flag registered so the pin comes straight from a flop
    s_nxt.loading  = (s_nxt.st == ST_LOAD) || (s_nxt.st == ST_BOOT);
  end

  // state register, boot load starts after every reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r         <= '0;
      s_r.st      <= ST_BOOT;
      s_r.loading <= 1'b1;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // firmware-data cells written by the host only
  always_ff @(posedge i_clk) begin
    if (i_ce && take && lk.we && is_fwd(lk.addr)) begin
      mem[cell_of(lk.addr)] <= lk.wdata;
    end
  end

  // outputs straight from the state register
  assign lk.ack      = s_r.ack;
  assign lk.rdata    = s_r.rdata;
  assign o_live_cfg  = s_r.live;
  assign o_pp_run    = s_r.live[PP_EN_IDX][PP_EN_BIT];
  assign o_tof_rate  = s_r.tof;
  assign o_min_amp   = s_r.min_amp;
  assign o_fw_opt    = s_r.fw_opt;
  assign o_fhl_prov  = s_r.fhl_prov;
  assign o_fhl       = s_r.fhl;
  assign o_loading   = s_r.loading;
  assign o_data_csum = s_r.csum;
  assign o_csum_ok   = s_r.csum_ok;
  assign o_wdt_reset = s_r.wdt_rst;
endmodule : cil_loader

// ### cil_host.sv
/*
  host end: avalon-mm slave with waitrequest taking orders from software,
  link master issuing single reads and writes to the loader end.
  assumes the loader answers every request with one ack.
*/
`timescale 1ns/1ps
module cil_host
  import cil_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic [1:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  output logic             o_busy,
  cil_link_if.hst          lk
);
  typedef struct packed {
    logic        wait_n;   // one-cycle answer window
    logic        waitreq;  // avalon waitrequest, high when idle
    logic [31:0] rd;       // avalon read data
    logic [8:0]  addr;     // link address register
    logic [31:0] wdata;    // link write data register
    logic [31:0] ldata;    // last link read data
    logic        req;      // link request
    logic        we;       // link direction
  } cil_hst_t;

  cil_hst_t s_r;           // registered state
  cil_hst_t s_nxt;         // next state
  logic     acc;           // avalon access answered this cycle

  assign acc = (i_read || i_write) && s_r.wait_n;

  // next-state logic
  always_comb begin
    s_nxt        = s_r;
    s_nxt.wait_n = (i_read || i_write) && !s_r.wait_n;
    // waitrequest kept in its own flop so the pin comes straight from it
    s_nxt.waitreq = !s_nxt.wait_n;
    // link transfer ends on ack
    if (s_r.req && lk.ack) begin
      s_nxt.req = 1'b0;
      if (!s_r.we) begin
        s_nxt.ldata = lk.rdata;
      end
    end
    // register reads, captured as the request is seen so the data stand
    // while waitrequest is low
    if (i_read && !s_r.wait_n) begin
      if (i_address == HR_ADDR) begin
        s_nxt.rd = {23'h0, s_r.addr};
      end else if (i_address == HR_WDATA) begin
        s_nxt.rd = s_r.wdata;
      end else if (i_address == HR_CMD) begin
        s_nxt.rd = {31'h0, s_r.req};
      end else begin
        s_nxt.rd = s_r.ldata;
      end
    end
    // register writes, ignored while a transfer is open
    if (acc && i_write && !s_r.req) begin
      if (i_address == HR_ADDR) begin
        s_nxt.addr = i_writedata[8:0];
      end else if (i_address == HR_WDATA) begin
        s_nxt.wdata = i_writedata;
      end else if (i_address == HR_CMD) begin
        if (i_writedata[CMD_ARM]) begin
          s_nxt.addr  = A_RELEASE;
          s_nxt.wdata = REL_CODE;
          s_nxt.we    = 1'b1;
          s_nxt.req   = 1'b1;
        end else if (i_writedata[CMD_GO]) begin
          s_nxt.we  = i_writedata[CMD_WR];
          s_nxt.req = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r         <= '0;
      s_r.waitreq <= 1'b1;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign o_readdata    = s_r.rd;
  assign o_waitrequest = s_r.waitreq;
  assign o_busy        = s_r.req;
  assign lk.req        = s_r.req;
  assign lk.we         = s_r.we;
  assign lk.addr       = s_r.addr;
  assign lk.wdata      = s_r.wdata;
endmodule : cil_host

// ### cil_link_sva.sv
/*
  link checker: handshake and data rules on the link between both ends.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module cil_link_sva
  import cil_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [8:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] rdata,
  input  wire logic        ack
);
  logic [8:0]  lw_addr_r;  // last link address written
  logic [31:0] lw_data_r;  // last data written
  logic        lw_vld_r;   // a write has been seen
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // remember the last completed write
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lw_addr_r <= 9'h000;
      lw_data_r <= 32'h0;
      lw_vld_r  <= 1'b0;
    end else if (req && we && ack) begin
      lw_addr_r <= addr;
      lw_data_r <= wdata;
      lw_vld_r  <= 1'b1;
    end
  end
  property p_ack_next; req && !ack |=> ack; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("link request not answered next cycle");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("link ack longer than one cycle");
  property p_ack_cause; $rose(ack) |-> $past(req) && !$past(ack); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("link ack without request");
  property p_req_drop; ack |=> !req; endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("link request kept after ack");
  property p_req_hold;
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("link request changed before ack");
  property p_no_idle_ack; !req |=> !ack; endproperty
  a_no_idle_ack: assert property (p_no_idle_ack)
    else $error("link ack while idle");
  property p_readback;
    req && !we && !ack && lw_vld_r && addr == lw_addr_r && addr[8] && addr < A_REFRESH
      |=> rdata == lw_data_r;
  endproperty
  a_readback: assert property (p_readback)
    else $error("stored cell read back wrong");
  property p_unmapped; req && !we && !ack && !addr[8] && addr > A_STAT |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped link read not zero");
endmodule : cil_link_sva

// ### config_image_boot_loader_tb_top.sv
/*
  testbench: host and loader ends joined by the link, driven over avalon-mm.
  assumes the package, the interface, both ends and the link checker.
*/
`timescale 1ns/1ps
module config_image_boot_loader_tb_top
  import cil_pkg::*;
;
  localparam logic [39:0] HOUR = 40'h0c8;  // shortened refresh period
  localparam logic [27:0] WDT  = 28'h064;  // shortened watchdog period
  logic        i_clk    = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        rd       = 1'b0;            // avalon read
  logic        wr       = 1'b0;            // avalon write
  logic        svc      = 1'b0;            // watchdog service
  logic [1:0]  adr      = 2'h0;
  logic [31:0] wd       = 32'h0;
  logic [31:0] avrd, rdat, min_amp, fw_opt, fhl_prov, fhl, dsum;
  logic [31:0] mem [0:127];                // mirror of cells written
  logic [CFG_WORDS-1:0][31:0] live;
  logic [7:0]  tof;
  logic        wreq, busy, pp, loading, csok, wdrst;
  int          mismatches  = 0;
  int          check_count = 0;
  // 20 MHz clock
  always #25 i_clk = ~i_clk;
  cil_link_if lk ();
  cil_host u_cil_host (.i_clk, .i_arst_n, .i_ce(1'b1), .i_address(adr), .i_read(rd),
    .i_write(wr), .i_writedata(wd), .o_readdata(avrd), .o_waitrequest(wreq),
    .o_busy(busy), .lk(lk.hst));
  cil_loader #(.P_HOUR_CYC(HOUR), .P_WDT_CYC(WDT), .P_FORCE(32'h0)) u_cil_loader (
    .i_clk, .i_arst_n, .i_ce(1'b1), .i_wdt_service(svc), .lk(lk.dev), .o_live_cfg(live),
    .o_pp_run(pp), .o_tof_rate(tof), .o_min_amp(min_amp), .o_fw_opt(fw_opt),
    .o_fhl_prov(fhl_prov), .o_fhl(fhl), .o_loading(loading), .o_data_csum(dsum),
    .o_csum_ok(csok), .o_wdt_reset(wdrst));
  cil_link_sva u_cil_link_sva (.i_clk, .i_arst_n, .req(lk.req), .we(lk.we),
    .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata), .ack(lk.ack));
  task automatic close_out;
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // a wait that ran out ends the run
  task automatic tmo;
    mismatches++;
    $display("ERROR at %0t: wait ran out", $time);
    close_out();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic avm(input logic w, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 50) tmo();
    end while (wreq);
    rdat = avrd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : avm
  // one link transfer ordered through the host registers
  task automatic lnk(input logic w, input logic [8:0] a, input logic [31:0] d,
                     input logic [2:0] cmd);
    int n;
    avm(1'b1, HR_ADDR, {23'h0, a});
    avm(1'b1, HR_WDATA, d);
    avm(1'b1, HR_CMD, {29'h0, cmd});
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 50) tmo();
    end while (busy);
    if (w && a[8]) mem[a[6:0]] = d;
    if (!w) avm(1'b0, HR_RDATA, 32'h0);
  endtask : lnk
  task automatic wr_c(input logic [8:0] a, input logic [31:0] d);
    lnk(1'b1, a, d, 3'h3);
  endtask : wr_c
  task automatic rd_c(input logic [8:0] a);
    lnk(1'b0, a, 32'h0, 3'h1);
  endtask : rd_c
  // wait for the boot load to finish
  task automatic wait_load;
    int n;
    n = 0;
    repeat (2) @(posedge i_clk);
    do begin
      @(posedge i_clk);
      n++;
      if (n > 100) tmo();
    end while (loading);
  endtask : wait_load
  task automatic do_reset;
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    wait_load();
  endtask : do_reset
  // main sequence
  initial begin
    logic [31:0] sum;
    int          n;
    do_reset();
    for (int i = 0; i < 124; i++) wr_c(9'h100 + 9'(i), 32'h0100_0000 + 32'(i));
    for (int i = 0; i < CFG_WORDS; i++) wr_c(A_REFRESH + 9'(i), 32'h5a00_0001 + 32'(i << 8));
    wr_c(A_PRC, 32'h1400_2824);
    // refresh off so an hourly load cannot swallow a checksum start
    wr_c(A_REFRESH, 32'h0);
    lnk(1'b1, A_RELEASE, REL_CODE, 3'h7);
    rd_c(A_RELEASE);
    chk(rdat, REL_CODE);
    wr_c(A_MIN_AMP, 32'h0000_0a5a);
    rd_c(A_MIN_AMP);
    chk(rdat, 32'h0000_0a5a);
    chk(min_amp, mem[85]);
    chk(fw_opt, mem[106]);
    chk(fhl_prov, mem[93]);
    chk(fhl, mem[107]);
    rd_c(9'h0f0);
    chk(rdat, 32'h0);
    sum = 32'h0;
    for (int i = 0; i < 124; i++) sum += mem[i];
    wr_c(A_CSUM_FIRST, sum);
    wr_c(A_CTRL, 32'h2);
    repeat (140) @(posedge i_clk);
    chk(dsum, sum);
    rd_c(A_STAT);
    chk(rdat, 32'h4);
    wr_c(A_CSUM_FIRST, sum + 32'h1);
    wr_c(A_CTRL, 32'h2);
    repeat (140) @(posedge i_clk);
    chk({31'h0, csok}, 32'h0);
    wr_c(A_REFRESH, 32'h8000_0000);
    do_reset();
    for (int i = 0; i < CFG_WORDS; i++) chk(live[i], mem[108 + i]);
    chk({24'h0, tof}, 32'h14);
    chk({31'h0, pp}, 32'h1);
    wr_c(9'h002, 32'hdead_beef);
    repeat (450) @(posedge i_clk);
    chk(live[2], mem[110]);
    wr_c(A_REFRESH, 32'h0);
    wr_c(9'h002, 32'hdead_beef);
    repeat (450) @(posedge i_clk);
    chk(live[2], 32'hdead_beef);
    wr_c(A_CTRL, 32'h1);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 300) tmo();
    end while (!wdrst);
    wait_load();
    chk(live[2], mem[110]);
    svc <= 1'b1;
    wr_c(A_RELEASE, 32'h0);
    do_reset();
    chk(live[1], 32'h0);
    chk({31'h0, pp}, 32'h0);
    close_out();
  end
endmodule : config_image_boot_loader_tb_top
